// *** hw/tcp_pkg.sv ***
// How it works
// - Each capture channel copies the 16-bit counter on an active pin edge
// - Software picks rising or falling capture edge per channel
// - A capture sets its flag; interrupt requested when enabled and unmasked
// - Capture flag clears after status read with flag set, then low-byte access
// - After a capture high-byte read, captures wait until the low byte is accessed
// - Capture pins always feed capture logic, whatever the pin direction
// - In single-pulse or PWM mode only capture channel 2 captures normally
// - Each compare register is matched against the counter every timer count
// - Compare registers are software owned only and reset to 8000h
// - On an enabled match the compare pin takes its level bit, pin 2 only outside single-pulse or PWM mode; low in reset
// - A compare match requests an interrupt when enabled and unmasked, except compare 1 in single-pulse or PWM mode and compare 2 in PWM mode
// - Compare flag clears after status read with flag set, then low-byte access
// - Compare high write inhibits compares until low write, which clears the flag
// - Flag and pin are set in the count where counter equals compare value
// - Disabled pin gets no level on match; interrupt still possible
// - Force bit copies level bit to the enabled pin with no flag or interrupt
// - Force bits do nothing in single-pulse or PWM mode
// - Single-pulse mode bit in control two uses capture 1 and compare 1
// - Trigger reloads FFFCh, drives level two, sets capture flag, loads FFFDh
// - In single-pulse mode compare 1 match drives level one, ending the pulse
// - Counter is 16-bit free-running, reloads only FFFCh, clock /2 /4 /8 or ext
// - Both clock-select bits set choose the external clock
package tcp_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFF_CTRL_TWO = 4'h0;
	localparam logic [3:0] OFF_CTRL_ONE = 4'h1;
	localparam logic [3:0] OFF_FLAGS = 4'h2;
	localparam logic [3:0] OFF_CAP1_HI = 4'h3;
	localparam logic [3:0] OFF_CAP1_LO = 4'h4;
	localparam logic [3:0] OFF_CMP1_HI = 4'h5;
	localparam logic [3:0] OFF_CMP1_LO = 4'h6;
	localparam logic [3:0] OFF_CNT_HI = 4'h7;
	localparam logic [3:0] OFF_CNT_LO = 4'h8;
	localparam logic [3:0] OFF_CAP2_HI = 4'h9;
	localparam logic [3:0] OFF_CAP2_LO = 4'ha;
	localparam logic [3:0] OFF_CMP2_HI = 4'hb;
	localparam logic [3:0] OFF_CMP2_LO = 4'hc;
	// ----------------------------------------------------------------
	// Control register two fields
	// ----------------------------------------------------------------
	localparam int B2_PIN1_EN = 7;
	localparam int B2_PIN2_EN = 6;
	localparam int B2_PULSE = 5;
	localparam int B2_PWM = 4;
	localparam int B2_CLK_HI = 3;
	localparam int B2_CLK_LO = 2;
	localparam int B2_EDGE2 = 1;
	localparam int B2_EXT_EDGE = 0;
	// ----------------------------------------------------------------
	// Control register one fields
	// ----------------------------------------------------------------
	localparam int B1_CAP_IE = 7;
	localparam int B1_CMP_IE = 6;
	localparam int B1_OVF_IE = 5;
	localparam int B1_FORCE2 = 4;
	localparam int B1_FORCE1 = 3;
	localparam int B1_LEVEL2 = 2;
	localparam int B1_EDGE1 = 1;
	localparam int B1_LEVEL1 = 0;
	// ----------------------------------------------------------------
	// Flags register fields
	// ----------------------------------------------------------------
	localparam int BF_CAP1 = 7;
	localparam int BF_CMP1 = 6;
	localparam int BF_OVF = 5;
	localparam int BF_CAP2 = 4;
	localparam int BF_CMP2 = 3;
	// ----------------------------------------------------------------
	// Values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] COMPARE_RESET = 16'h8000;
	localparam logic [15:0] COUNTER_RELOAD = 16'hfffc;
	localparam logic [15:0] PULSE_CAPTURE_VALUE = 16'hfffd;
	localparam logic [15:0] COUNTER_TOP = 16'hffff;
	localparam logic [1:0] CLK_DIV4 = 2'h0;
	localparam logic [1:0] CLK_DIV2 = 2'h1;
	localparam logic [1:0] CLK_DIV8 = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	localparam logic [2:0] LAST_DIV2 = 3'h1;
	localparam logic [2:0] LAST_DIV4 = 3'h3;
	localparam logic [2:0] LAST_DIV8 = 3'h7;
endpackage

// *** hw/tcp_cap_if.sv ***
`timescale 1ns/1ps
interface tcp_cap_if;
	logic capEvent;
	logic loadFixed;
	logic hiRead;
	logic loAccess;
	logic srRead;
	logic [15:0] counter;
	logic [15:0] value;
	logic flag;

	modport owner (output capEvent, output loadFixed, output hiRead, output loAccess, output srRead,
		output counter, input value, input flag);
	modport chan (input capEvent, input loadFixed, input hiRead, input loAccess, input srRead,
		input counter, output value, output flag);
endinterface

// *** hw/tcp_sync.sv ***
`timescale 1ns/1ps
module tcp_sync (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;
	logic [2:0] fill_reg;
	wire agree = s2_reg == s3_reg;
	// No edge until the stages hold the pin, so an idle-high pin gives no edge after reset
	wire primed = fill_reg[2];

	// ----------------------------------------------------------------
	// Three stages; a change counts when the last two agree
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
			fill_reg <= 3'h0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			fill_reg <= primed ? fill_reg : fill_reg + 3'h1;
			level_reg <= (agree | ~primed) ? s3_reg : level_reg;
			rise <= primed & agree & s3_reg & ~level_reg;
			fall <= primed & agree & ~s3_reg & level_reg;
		end
	end
endmodule

// *** hw/tcp_capture.sv ***
`timescale 1ns/1ps
module tcp_capture (
	input wire logic clock,
	input wire logic arst_n,
	tcp_cap_if.chan bus
);
	logic [15:0] value_reg;
	logic flag_reg;
	logic armed_reg;
	logic hold_reg;

	// ----------------------------------------------------------------
	// Capture, flag and clearing sequence
	// ----------------------------------------------------------------
	wire take = bus.capEvent & ~hold_reg;
	wire setFlag = take | bus.loadFixed;
	wire [15:0] value_next = bus.loadFixed ? tcp_pkg::PULSE_CAPTURE_VALUE : (take ? bus.counter : value_reg);
	wire flag_next = setFlag | (flag_reg & ~(armed_reg & bus.loAccess));
	wire armed_next = (bus.srRead & flag_reg) | (armed_reg & ~bus.loAccess);
	wire hold_next = bus.hiRead | (hold_reg & ~bus.loAccess);

	assign bus.value = value_reg;
	assign bus.flag = flag_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			value_reg <= 16'h0000;
			flag_reg <= 1'b0;
			armed_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			value_reg <= value_next;
			flag_reg <= flag_next;
			armed_reg <= armed_next;
			hold_reg <= hold_next;
		end
	end
endmodule

// *** hw/tcp_top.sv ***
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module tcp_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	input wire logic capPin1,
	input wire logic capPin2,
	input wire logic extClkPin,
	input wire logic cpuIrqMask,
	output logic cmpPin1,
	output logic cmpPin2,
	output logic cmpPinEnable1,
	output logic cmpPinEnable2,
	output logic timerIrq
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] ctrlTwo_reg;
	logic [7:0] ctrlOne_reg;
	logic [15:0] compareValueOne_reg;
	logic [15:0] compareValueTwo_reg;
	logic [15:0] counter_reg;
	logic [2:0] presc_reg;
	logic moved_reg;
	logic cmpFlag1_reg;
	logic cmpFlag2_reg;
	logic cmpArmed1_reg;
	logic cmpArmed2_reg;
	logic cmpHold1_reg;
	logic cmpHold2_reg;
	logic ovfFlag_reg;
	logic ovfArmed_reg;
	logic cap1Rise;
	logic cap1Fall;
	logic cap2Rise;
	logic cap2Fall;
	logic extRise;
	logic extFall;

	tcp_cap_if capOne();
	tcp_cap_if capTwo();

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	tcp_sync syncCap1 (
		.clock(clock),
		.arst_n(arst_n),
		.pin(capPin1),
		.rise(cap1Rise),
		.fall(cap1Fall)
	);
	tcp_sync syncCap2 (
		.clock(clock),
		.arst_n(arst_n),
		.pin(capPin2),
		.rise(cap2Rise),
		.fall(cap2Fall)
	);
	tcp_sync syncExt (
		.clock(clock),
		.arst_n(arst_n),
		.pin(extClkPin),
		.rise(extRise),
		.fall(extFall)
	);

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	wire wrCtrlTwo = wrStrobe & (addr == tcp_pkg::OFF_CTRL_TWO);
	wire wrCtrlOne = wrStrobe & (addr == tcp_pkg::OFF_CTRL_ONE);
	wire rdFlags = rdStrobe & (addr == tcp_pkg::OFF_FLAGS);
	wire anyAccess = wrStrobe | rdStrobe;
	wire cap1HiRead = rdStrobe & (addr == tcp_pkg::OFF_CAP1_HI);
	wire cap2HiRead = rdStrobe & (addr == tcp_pkg::OFF_CAP2_HI);
	wire cap1LoAccess = anyAccess & (addr == tcp_pkg::OFF_CAP1_LO);
	wire cap2LoAccess = anyAccess & (addr == tcp_pkg::OFF_CAP2_LO);
	wire wrCmp1Hi = wrStrobe & (addr == tcp_pkg::OFF_CMP1_HI);
	wire wrCmp2Hi = wrStrobe & (addr == tcp_pkg::OFF_CMP2_HI);
	wire wrCmp1Lo = wrStrobe & (addr == tcp_pkg::OFF_CMP1_LO);
	wire wrCmp2Lo = wrStrobe & (addr == tcp_pkg::OFF_CMP2_LO);
	wire cmp1LoAccess = anyAccess & (addr == tcp_pkg::OFF_CMP1_LO);
	wire cmp2LoAccess = anyAccess & (addr == tcp_pkg::OFF_CMP2_LO);
	wire cntLoAccess = anyAccess & (addr == tcp_pkg::OFF_CNT_LO);
	wire cntLoWrite = wrStrobe & (addr == tcp_pkg::OFF_CNT_LO);

	// ----------------------------------------------------------------
	// Modes
	// ----------------------------------------------------------------
	wire pwmMode = ctrlTwo_reg[tcp_pkg::B2_PWM];
	wire pulseMode = ctrlTwo_reg[tcp_pkg::B2_PULSE] & ~pwmMode;
	wire specialMode = pulseMode | pwmMode;
	wire [1:0] clkSel = {ctrlTwo_reg[tcp_pkg::B2_CLK_HI], ctrlTwo_reg[tcp_pkg::B2_CLK_LO]};
	wire pin1Enable = ctrlTwo_reg[tcp_pkg::B2_PIN1_EN];
	wire pin2Enable = ctrlTwo_reg[tcp_pkg::B2_PIN2_EN];
	wire level1 = ctrlOne_reg[tcp_pkg::B1_LEVEL1];
	wire level2 = ctrlOne_reg[tcp_pkg::B1_LEVEL2];

	// ----------------------------------------------------------------
	// Timer clock and counter
	// ----------------------------------------------------------------
	wire [2:0] prescLast = (clkSel == tcp_pkg::CLK_DIV2) ? tcp_pkg::LAST_DIV2 :
		((clkSel == tcp_pkg::CLK_DIV8) ? tcp_pkg::LAST_DIV8 : tcp_pkg::LAST_DIV4);
	wire prescWrap = presc_reg >= prescLast;
	wire extEdge = ctrlTwo_reg[tcp_pkg::B2_EXT_EDGE] ? extRise : extFall;
	wire useExt = clkSel == tcp_pkg::CLK_EXT;
	wire timerTick = useExt ? extEdge : prescWrap;
	wire [2:0] presc_next = (prescWrap | useExt) ? 3'h0 : presc_reg + 3'h1;

	// Capture edge selection, always fed from the pins
	wire edge1 = ctrlOne_reg[tcp_pkg::B1_EDGE1] ? cap1Rise : cap1Fall;
	wire edge2 = ctrlTwo_reg[tcp_pkg::B2_EDGE2] ? cap2Rise : cap2Fall;
	wire pulseTrigger = pulseMode & edge1;

	wire reload = pulseTrigger | cntLoWrite;
	wire [15:0] counter_next = reload ? tcp_pkg::COUNTER_RELOAD :
		(timerTick ? counter_reg + 16'h0001 : counter_reg);
	wire moved_next = reload | timerTick;
	wire overflow = timerTick & ~reload & (counter_reg == tcp_pkg::COUNTER_TOP);

	// ----------------------------------------------------------------
	// Compare channels
	// ----------------------------------------------------------------
	wire eq1 = counter_reg == compareValueOne_reg;
	wire eq2 = counter_reg == compareValueTwo_reg;
	wire match1 = moved_reg & eq1 & ~cmpHold1_reg;
	wire match2 = moved_reg & eq2 & ~cmpHold2_reg;
	wire setCmp1 = match1 & ~specialMode;
	wire setCmp2 = match2 & ~pwmMode;
	wire cmpFlag1_next = setCmp1 | (cmpFlag1_reg & ~(wrCmp1Lo | (cmpArmed1_reg & cmp1LoAccess)));
	wire cmpFlag2_next = setCmp2 | (cmpFlag2_reg & ~(wrCmp2Lo | (cmpArmed2_reg & cmp2LoAccess)));
	wire cmpArmed1_next = (rdFlags & cmpFlag1_reg) | (cmpArmed1_reg & ~cmp1LoAccess);
	wire cmpArmed2_next = (rdFlags & cmpFlag2_reg) | (cmpArmed2_reg & ~cmp2LoAccess);
	wire cmpHold1_next = wrCmp1Hi | (cmpHold1_reg & ~wrCmp1Lo);
	wire cmpHold2_next = wrCmp2Hi | (cmpHold2_reg & ~wrCmp2Lo);

	// Compare values change only by software writes
	wire [15:0] cmpOne_next = wrCmp1Hi ? {wrData, compareValueOne_reg[7:0]} :
		(wrCmp1Lo ? {compareValueOne_reg[15:8], wrData} : compareValueOne_reg);
	wire [15:0] cmpTwo_next = wrCmp2Hi ? {wrData, compareValueTwo_reg[7:0]} :
		(wrCmp2Lo ? {compareValueTwo_reg[15:8], wrData} : compareValueTwo_reg);

	// ----------------------------------------------------------------
	// Overflow flag
	// ----------------------------------------------------------------
	wire ovfFlag_next = overflow | (ovfFlag_reg & ~(ovfArmed_reg & cntLoAccess));
	wire ovfArmed_next = (rdFlags & ovfFlag_reg) | (ovfArmed_reg & ~cntLoAccess);

	// ----------------------------------------------------------------
	// Output pins
	// ----------------------------------------------------------------
	wire force1 = wrCtrlOne & wrData[tcp_pkg::B1_FORCE1] & ~specialMode;
	wire force2 = wrCtrlOne & wrData[tcp_pkg::B1_FORCE2] & ~specialMode;
	wire forceLevel1 = wrData[tcp_pkg::B1_LEVEL1];
	wire forceLevel2 = wrData[tcp_pkg::B1_LEVEL2];
	wire pin1Next = ~pin1Enable ? cmpPin1 :
		(pulseTrigger ? level2 :
		(match1 ? level1 :
		(force1 ? forceLevel1 : cmpPin1)));
	wire pin2Next = ~pin2Enable ? cmpPin2 :
		(match2 & ~specialMode ? level2 :
		(force2 ? forceLevel2 : cmpPin2));

	// ----------------------------------------------------------------
	// Interrupt request
	// ----------------------------------------------------------------
	wire capPending = ctrlOne_reg[tcp_pkg::B1_CAP_IE] & (capOne.flag | capTwo.flag);
	wire cmpPending = ctrlOne_reg[tcp_pkg::B1_CMP_IE] & (cmpFlag1_reg | cmpFlag2_reg);
	wire ovfPending = ctrlOne_reg[tcp_pkg::B1_OVF_IE] & ovfFlag_reg;
	wire irqNext = ~cpuIrqMask & (capPending | cmpPending | ovfPending);

	// ----------------------------------------------------------------
	// Capture channel hookup
	// ----------------------------------------------------------------
	assign capOne.capEvent = edge1 & ~specialMode;
	assign capOne.loadFixed = pulseTrigger;
	assign capOne.hiRead = cap1HiRead;
	assign capOne.loAccess = cap1LoAccess;
	assign capOne.srRead = rdFlags;
	assign capOne.counter = counter_reg;
	assign capTwo.capEvent = edge2;
	assign capTwo.loadFixed = 1'b0;
	assign capTwo.hiRead = cap2HiRead;
	assign capTwo.loAccess = cap2LoAccess;
	assign capTwo.srRead = rdFlags;
	assign capTwo.counter = counter_reg;

	tcp_capture chanOne (
		.clock(clock),
		.arst_n(arst_n),
		.bus(capOne.chan)
	);
	tcp_capture chanTwo (
		.clock(clock),
		.arst_n(arst_n),
		.bus(capTwo.chan)
	);

	// ----------------------------------------------------------------
	// Read data selection
	// ----------------------------------------------------------------
	wire [7:0] flagsByte = {capOne.flag, cmpFlag1_reg, ovfFlag_reg, capTwo.flag, cmpFlag2_reg, 3'h0};
	wire [7:0] ctrlOneRead = ctrlOne_reg & ~8'h18;
	wire [7:0] readMux =
		(addr == tcp_pkg::OFF_CTRL_TWO) ? ctrlTwo_reg :
		(addr == tcp_pkg::OFF_CTRL_ONE) ? ctrlOneRead :
		(addr == tcp_pkg::OFF_FLAGS) ? flagsByte :
		(addr == tcp_pkg::OFF_CAP1_HI) ? capOne.value[15:8] :
		(addr == tcp_pkg::OFF_CAP1_LO) ? capOne.value[7:0] :
		(addr == tcp_pkg::OFF_CMP1_HI) ? compareValueOne_reg[15:8] :
		(addr == tcp_pkg::OFF_CMP1_LO) ? compareValueOne_reg[7:0] :
		(addr == tcp_pkg::OFF_CNT_HI) ? counter_reg[15:8] :
		(addr == tcp_pkg::OFF_CNT_LO) ? counter_reg[7:0] :
		(addr == tcp_pkg::OFF_CAP2_HI) ? capTwo.value[15:8] :
		(addr == tcp_pkg::OFF_CAP2_LO) ? capTwo.value[7:0] :
		(addr == tcp_pkg::OFF_CMP2_HI) ? compareValueTwo_reg[15:8] :
		(addr == tcp_pkg::OFF_CMP2_LO) ? compareValueTwo_reg[7:0] : 8'h00;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrlTwo_reg <= tcp_pkg::CTRL_RESET;
			ctrlOne_reg <= tcp_pkg::CTRL_RESET;
		end else begin
			ctrlTwo_reg <= wrCtrlTwo ? wrData : ctrlTwo_reg;
			ctrlOne_reg <= wrCtrlOne ? wrData : ctrlOne_reg;
		end
	end

	// ----------------------------------------------------------------
	// Counter and prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			counter_reg <= tcp_pkg::COUNTER_RELOAD;
			presc_reg <= 3'h0;
			moved_reg <= 1'b0;
			ovfFlag_reg <= 1'b0;
			ovfArmed_reg <= 1'b0;
		end else begin
			counter_reg <= counter_next;
			presc_reg <= reload ? 3'h0 : presc_next;
			moved_reg <= moved_next;
			ovfFlag_reg <= ovfFlag_next;
			ovfArmed_reg <= ovfArmed_next;
		end
	end

	// ----------------------------------------------------------------
	// Compare registers and flags
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			compareValueOne_reg <= tcp_pkg::COMPARE_RESET;
			compareValueTwo_reg <= tcp_pkg::COMPARE_RESET;
			cmpFlag1_reg <= 1'b0;
			cmpFlag2_reg <= 1'b0;
			cmpArmed1_reg <= 1'b0;
			cmpArmed2_reg <= 1'b0;
			cmpHold1_reg <= 1'b0;
			cmpHold2_reg <= 1'b0;
		end else begin
			compareValueOne_reg <= cmpOne_next;
			compareValueTwo_reg <= cmpTwo_next;
			cmpFlag1_reg <= cmpFlag1_next;
			cmpFlag2_reg <= cmpFlag2_next;
			cmpArmed1_reg <= cmpArmed1_next;
			cmpArmed2_reg <= cmpArmed2_next;
			cmpHold1_reg <= cmpHold1_next;
			cmpHold2_reg <= cmpHold2_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cmpPin1 <= 1'b0;
			cmpPin2 <= 1'b0;
			cmpPinEnable1 <= 1'b0;
			cmpPinEnable2 <= 1'b0;
			timerIrq <= 1'b0;
			rdData <= 8'h00;
		end else begin
			cmpPin1 <= pin1Next;
			cmpPin2 <= pin2Next;
			cmpPinEnable1 <= pin1Enable;
			cmpPinEnable2 <= pin2Enable;
			timerIrq <= irqNext;
			rdData <= rdStrobe ? readMux : 8'h00;
		end
	end
endmodule

// *** testbench/tcp_properties.sv ***
`timescale 1ns/1ps
module tcp_properties (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [7:0] rdData,
	input wire logic cpuIrqMask,
	input wire logic cmpPin1,
	input wire logic cmpPin2,
	input wire logic cmpPinEnable1,
	input wire logic cmpPinEnable2,
	input wire logic timerIrq
);
	// ----
	// Shadow of the control registers
	// ----
	logic [7:0] ctl1Reg;
	logic [7:0] ctl2Reg;
	wire wrCtl1 = wrStrobe && addr == tcp_pkg::OFF_CTRL_ONE;
	wire wrCtl2 = wrStrobe && addr == tcp_pkg::OFF_CTRL_TWO;
	wire modeOn = ctl2Reg[tcp_pkg::B2_PULSE] || ctl2Reg[tcp_pkg::B2_PWM];
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctl1Reg <= 8'h00;
			ctl2Reg <= 8'h00;
		end else begin
			if (wrCtl1) ctl1Reg <= wrData;
			if (wrCtl2) ctl2Reg <= wrData;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	property p_rd_idle;
		!$past(rdStrobe) |-> rdData == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
	property p_cmp_rw;
		wrStrobe && addr == tcp_pkg::OFF_CMP1_HI ##2 rdStrobe && addr == tcp_pkg::OFF_CMP1_HI
			|=> rdData == $past(wrData, 3);
	endproperty
	a_cmp_rw: assert property (p_cmp_rw) else $error("compare high byte read back wrong");
	property p_pin_en;
		wrCtl2 |-> ##2 cmpPinEnable1 == ctl2Reg[7] && cmpPinEnable2 == ctl2Reg[6];
	endproperty
	a_pin_en: assert property (p_pin_en) else $error("pin enable not following control");
	property p_force1;
		wrCtl1 && wrData[tcp_pkg::B1_FORCE1] && cmpPinEnable1 && !modeOn
			|-> ##2 cmpPin1 == $past(wrData[tcp_pkg::B1_LEVEL1], 2);
	endproperty
	a_force1: assert property (p_force1) else $error("forced level missing on pin one");
	property p_force_mode;
		wrCtl1 && wrData[tcp_pkg::B1_FORCE2] && modeOn |=> $stable(cmpPin2) ##1 $stable(cmpPin2);
	endproperty
	a_force_mode: assert property (p_force_mode) else $error("force acted in pulse mode");
	property p_pin2_gate;
		$changed(cmpPin2) |-> cmpPinEnable2;
	endproperty
	a_pin2_gate: assert property (p_pin2_gate) else $error("disabled pin two changed");
	property p_mask;
		cpuIrqMask |=> !timerIrq;
	endproperty
	a_mask: assert property (p_mask) else $error("interrupt while masked");
	property p_no_en;
		ctl1Reg[7:5] == 3'h0 |=> !timerIrq;
	endproperty
	a_no_en: assert property (p_no_en) else $error("interrupt with all enables off");
endmodule

bind tcp_top tcp_properties tcp_properties_i (.clock(clock), .arst_n(arst_n), .addr(addr),
	.wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .cpuIrqMask(cpuIrqMask),
	.cmpPin1(cmpPin1), .cmpPin2(cmpPin2), .cmpPinEnable1(cmpPinEnable1), .cmpPinEnable2(cmpPinEnable2),
	.timerIrq(timerIrq));

// *** testbench/tcp_pin_model.sv ***
`timescale 1ns/1ps
module tcp_pin_model (
	input wire logic clock,
	output logic capPin1,
	output logic capPin2,
	output logic extClkPin
);
	// ----
	// Capture pins idle high on their pull-ups; timer clock rising edges seven cycles apart
	// ----
	initial begin
		capPin1 = 1'b1;
		capPin2 = 1'b1;
		extClkPin = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clock);
			extClkPin <= 1'b1;
			repeat (3) @(posedge clock);
			extClkPin <= 1'b0;
			repeat (3) @(posedge clock);
		end
	endtask
	task automatic pulse(input logic [1:0] sel, input int n);
		@(posedge clock);
		if (sel[0]) capPin1 <= 1'b0;
		if (sel[1]) capPin2 <= 1'b0;
		repeat (6) @(posedge clock);
		tick(n);
		capPin1 <= 1'b1;
		capPin2 <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
endmodule

// *** testbench/tcp_top_tb.sv ***
`timescale 1ns/1ps
module tcp_top_tb;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wrData = 8'h00;
	logic wrStrobe = 1'b0;
	logic rdStrobe = 1'b0;
	logic cpuIrqMask = 1'b0;
	logic [7:0] rdData;
	logic capPin1, capPin2, extClkPin, cmpPin1, cmpPin2, cmpEn1, cmpEn2, timerIrq;
	logic [15:0] expQ[$];
	logic rdPend = 1'b0;
	logic [31:0] lfsrReg = 32'hd0127098;
	int error_cnt = 0;
	int n_compared = 0;
	always #50 clock = ~clock;
	tcp_top tcp_top_i (.clock(clock), .arst_n(arst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .capPin1(capPin1), .capPin2(capPin2), .extClkPin(extClkPin),
		.cpuIrqMask(cpuIrqMask), .cmpPin1(cmpPin1), .cmpPin2(cmpPin2), .cmpPinEnable1(cmpEn1),
		.cmpPinEnable2(cmpEn2), .timerIrq(timerIrq));
	tcp_pin_model tcp_pin_model_i (.clock(clock), .capPin1(capPin1), .capPin2(capPin2), .extClkPin(extClkPin));
	// ----
	// Bus tasks, read watcher and verdict
	// ----
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clock);
		wrStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		@(posedge clock);
		addr <= a;
		rdStrobe <= 1'b1;
		expQ.push_back({m, e});
		@(posedge clock);
		rdStrobe <= 1'b0;
	endtask
	task automatic rd16(input logic [3:0] a, input logic [15:0] v);
		rd(a, v[15:8]);
		rd(a + 4'h1, v[7:0]);
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 4'h1, v[7:0]);
	endtask
	always @(posedge clock) begin
		if (rdPend) begin
			check("rdData", rdData & expQ[0][15:8], expQ[0][7:0]);
			void'(expQ.pop_front());
		end
		rdPend <= rdStrobe;
	end
	task automatic report_and_stop();
		if (expQ.size() != 0) error_cnt++;
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clock);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		logic [3:0] a;
		logic [15:0] v;
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		rd16(tcp_pkg::OFF_CMP1_HI, tcp_pkg::COMPARE_RESET);
		rd16(tcp_pkg::OFF_CMP2_HI, tcp_pkg::COMPARE_RESET);
		rd(4'hf, 8'h00);
		for (int i = 0; i < 4; i++) begin
			lfsrReg = lfsr(lfsrReg);
			a = i[0] ? tcp_pkg::OFF_CMP2_HI : tcp_pkg::OFF_CMP1_HI;
			wr(a, lfsrReg[15:8]);
			rd(a, lfsrReg[15:8]);
			wr(a + 4'h1, lfsrReg[7:0]);
			rd(a + 4'h1, lfsrReg[7:0]);
		end
		// Captures on falling then rising edges, counter driven by the timer clock pin
		for (int e = 0; e < 2; e++) begin
			wr(tcp_pkg::OFF_CTRL_TWO, {4'h0, tcp_pkg::CLK_EXT, e[0], 1'b1});
			wr(tcp_pkg::OFF_CTRL_ONE, {1'b1, 5'h00, e[0], 1'b0});
			wr(tcp_pkg::OFF_CNT_LO, 8'h00);
			tcp_pin_model_i.pulse(2'h3, 2);
			v = tcp_pkg::COUNTER_RELOAD + {14'h0, e[0], 1'b0};
			check("timerIrq", {7'h0, timerIrq}, 8'h01);
			rd(tcp_pkg::OFF_FLAGS, 8'h90, 8'h90);
			rd16(tcp_pkg::OFF_CAP1_HI, v);
			rd16(tcp_pkg::OFF_CAP2_HI, v);
			rd(tcp_pkg::OFF_FLAGS, 8'h00, 8'h90);
		end
		rd(tcp_pkg::OFF_CAP1_HI, 8'hff);
		tcp_pin_model_i.pulse(2'h1, 1);
		rd(tcp_pkg::OFF_CAP1_LO, 8'hfe);
		rd(tcp_pkg::OFF_FLAGS, 8'h00, 8'h80);
		cpuIrqMask <= 1'b1;
		tcp_pin_model_i.pulse(2'h2, 0);
		check("timerIrq", {7'h0, timerIrq}, 8'h00);
		cpuIrqMask <= 1'b0;
		repeat (3) @(posedge clock);
		check("timerIrq", {7'h0, timerIrq}, 8'h01);
		rd(tcp_pkg::OFF_FLAGS, 8'h10, 8'h10);
		rd16(tcp_pkg::OFF_CAP2_HI, 16'hffff);
		// Compare matches, pin two left disabled
		wr(tcp_pkg::OFF_CTRL_TWO, 8'h8f);
		wr(tcp_pkg::OFF_CTRL_ONE, 8'h45);
		wr16(tcp_pkg::OFF_CMP1_HI, 16'hfffe);
		wr16(tcp_pkg::OFF_CMP2_HI, 16'hfffe);
		wr(tcp_pkg::OFF_CNT_LO, 8'h00);
		tcp_pin_model_i.tick(2);
		repeat (2) @(posedge clock);
		check("cmpPin1", {7'h0, cmpPin1}, 8'h01);
		check("cmpPin2", {7'h0, cmpPin2}, 8'h00);
		check("timerIrq", {7'h0, timerIrq}, 8'h01);
		rd(tcp_pkg::OFF_FLAGS, 8'h48, 8'h48);
		rd(tcp_pkg::OFF_CMP1_LO, 8'hfe);
		wr(tcp_pkg::OFF_CMP2_HI, 8'hff);
		rd(tcp_pkg::OFF_CMP2_LO, 8'hfe);
		rd(tcp_pkg::OFF_FLAGS, 8'h00, 8'h48);
		wr(tcp_pkg::OFF_CNT_LO, 8'h00);
		tcp_pin_model_i.tick(2);
		rd(tcp_pkg::OFF_FLAGS, 8'h40, 8'h48);
		wr(tcp_pkg::OFF_CMP2_LO, 8'hfe);
		rd(tcp_pkg::OFF_CMP1_LO, 8'hfe);
		// Forced levels, then single pulse with a blocked force
		wr(tcp_pkg::OFF_CTRL_TWO, 8'hcf);
		wr(tcp_pkg::OFF_CTRL_ONE, 8'h1c);
		wr(tcp_pkg::OFF_CTRL_ONE, 8'h10);
		check("cmpPin1", {7'h0, cmpPin1}, 8'h00);
		rd(tcp_pkg::OFF_FLAGS, 8'h00, 8'h48);
		wr(tcp_pkg::OFF_CTRL_TWO, 8'hef);
		wr(tcp_pkg::OFF_CTRL_ONE, 8'h16);
		tcp_pin_model_i.pulse(2'h1, 0);
		check("cmpPin1", {7'h0, cmpPin1}, 8'h01);
		check("cmpPin2", {7'h0, cmpPin2}, 8'h00);
		rd16(tcp_pkg::OFF_CAP1_HI, tcp_pkg::PULSE_CAPTURE_VALUE);
		rd(tcp_pkg::OFF_FLAGS, 8'h80, 8'hc0);
		tcp_pin_model_i.tick(2);
		repeat (2) @(posedge clock);
		check("cmpPin1", {7'h0, cmpPin1}, 8'h00);
		repeat (4) @(posedge clock);
		report_and_stop();
	end
endmodule
